// >>> hw/psit_defs.svh
`ifndef PSIT_DEFS_SVH
`define PSIT_DEFS_SVH

// ----------------------------------------------------------------
// memory and port map of the support logic
// ----------------------------------------------------------------
`define MEM_AW 10
`define ROM_PAGE 6'h00
`define RAM_PAGE 6'h01
`define PORT_KBD 8'h00
`define PORT_IND 8'h01
`define PORT_MASK 8'h02
`define PORT_TMR 8'h03

// ----------------------------------------------------------------
// reset values and bus constants
// ----------------------------------------------------------------
`define IND_RST 8'h00
`define MASK_RST 6'h00
`define PRESET_RST 8'h00
`define BUS_FLOAT 8'hff
`define VEC_PAD 5'h00

// ----------------------------------------------------------------
// timer rate: tick at 1.8432 MHz out of the 250 MHz clock
// ----------------------------------------------------------------
`define SYS_CLK_HZ 250000000
`define TMR_CLK_HZ 1843200
`define TMR_GCD 3200
`define TMR_INC (`TMR_CLK_HZ / `TMR_GCD)
`define TMR_MOD (`SYS_CLK_HZ / `TMR_GCD)
`define ACC_W 17

// ----------------------------------------------------------------
// host controller: link timing and register offsets
// ----------------------------------------------------------------
`define LINK_ACC_CYC 3
`define CMD_CLR 3'h6
`define REG_ADDR 8'h00
`define REG_WDATA 8'h04
`define REG_CMD 8'h08
`define REG_RDATA 8'h0c
`define REG_ISTAT 8'h10
`define REG_IMASK 8'h14
`define REG_LINK 8'h18
`define EV_DONE 0
`define EV_INTR 1

`endif

// >>> hw/psit_pkg.sv
`include "psit_defs.svh"

package psit_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    OP_IDLE = 3'b000,
    OP_MEMR = 3'b001,
    OP_MEMW = 3'b010,
    OP_IOR = 3'b011,
    OP_IOW = 3'b100,
    OP_INTA = 3'b101
  } bus_op_t;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_RUN = 2'b01,
    H_PULSE = 2'b10
  } host_st_t;

  typedef struct packed {
    logic [5:0] mask;
    logic [7:0] status;
    logic [2:0] vec;
    byte_t ind;
    byte_t preset;
    logic [3:0][3:0] cnt;
    logic [`ACC_W-1:0] acc;
    bus_op_t op_prev;
    byte_t rdata;
  } dev_state_t;

  typedef struct packed {
    host_st_t st;
    logic [7:0] cnt;
    logic [15:0] addr;
    byte_t wdata;
    byte_t rdata;
    bus_op_t op;
    logic clr_n;
    logic [1:0] istat;
    logic [1:0] imask;
    logic intr_prev;
    logic ack;
    logic [31:0] dat;
  } host_state_t;

endpackage : psit_pkg

// >>> hw/cpu_link_if.sv
`timescale 1ns/1ns
`include "psit_defs.svh"

interface cpu_link_if;
  import psit_pkg::*;

  bus_op_t op;
  logic [15:0] addr;
  byte_t host_d;
  logic host_oe;
  byte_t dev_d;
  logic dev_oe;
  logic intr_n;
  logic clr_n;
  byte_t data;

  // resolved system data bus; pulled high when nobody drives
  assign data = dev_oe ? dev_d : (host_oe ? host_d : `BUS_FLOAT);

  modport dev (
    input op, addr, clr_n, data,
    output dev_d, dev_oe, intr_n
  );

  modport host (
    input data, intr_n,
    output op, addr, host_d, host_oe, clr_n
  );

endinterface : cpu_link_if

// >>> hw/support_dev.sv
// What this block does
// - eight request lines, vectored prioritised interrupts
// - six-bit mask latch loaded from local bus
// - request inputs are active low
// - masked requests clocked into status latch
// - priority encoder gives three-bit code, request
// - vector latched when processor acknowledges interrupt
// - vector driven onto system bus during read
// - reset pulse clears the latched request
// - timer is four cascaded 4-bit counters
// - upper two stages preset by output write
// - intervals from 139 us to 35.6 ms
// - status decode gives read, write, acknowledge
// - bidirectional buffers join local and system
// - buffers enabled by address and strobe
// - unlatched keyboard port read live
// - one 8-bit indicator output port
// - 1024 bytes ROM and 1024 bytes RAM
`timescale 1ns/1ns
`include "psit_defs.svh"

module support_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  cpu_link_if.dev link,
  input wire logic [7:0] req_n_i,
  input psit_pkg::byte_t kbd_i,
  output psit_pkg::byte_t ind_o,
  input wire logic rom_wr_i,
  input wire logic [`MEM_AW-1:0] rom_addr_i,
  input psit_pkg::byte_t rom_data_i
);
  import psit_pkg::*;

  localparam int MEM_DEPTH = 1 << `MEM_AW;
  localparam int NSTAGE = 4;

  dev_state_t s_r;
  dev_state_t s_nxt;

  byte_t rom_mem [MEM_DEPTH];
  byte_t ram_mem [MEM_DEPTH];

  logic rd_stb;
  logic wr_stb;
  logic inta_stb;
  logic first_inta;
  logic mem_op;
  logic rom_hit;
  logic ram_hit;
  logic kbd_hit;
  logic ind_hit;
  logic mask_hit;
  logic tmr_hit;
  logic buf_en;
  logic to_sys;
  byte_t loc_d;
  logic [7:0] port_sel;
  logic [`MEM_AW-1:0] mem_a;
  logic [`ACC_W-1:0] acc_sum;
  logic tick;
  logic [NSTAGE:0] carry;
  logic terminal;
  logic [7:0] enable;
  logic [7:0] set_v;
  logic [7:0] clr_v;
  logic [2:0] enc;
  logic [2:0] vec_now;

  // ----------------------------------------------------------------
  // priority encoder
  // ----------------------------------------------------------------
  // highest line number wins; line 7 also carries the timer
  function automatic logic [2:0] prio_enc(input logic [7:0] pend);
    logic [2:0] code;
    code = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (pend[i]) begin
        code = 3'(i);
      end
    end
    return code;
  endfunction : prio_enc

  // ----------------------------------------------------------------
  // system controller and address decode
  // ----------------------------------------------------------------
  // status decode to strobes
  assign rd_stb = (link.op == OP_MEMR) || (link.op == OP_IOR)
    || (link.op == OP_INTA);
  assign wr_stb = (link.op == OP_MEMW) || (link.op == OP_IOW);
  assign inta_stb = (link.op == OP_INTA);
  assign first_inta = inta_stb && (s_r.op_prev != OP_INTA);

  assign mem_op = (link.op == OP_MEMR) || (link.op == OP_MEMW);
  assign mem_a = link.addr[`MEM_AW-1:0];
  assign rom_hit = mem_op && (link.addr[15:`MEM_AW] == `ROM_PAGE);
  assign ram_hit = mem_op && (link.addr[15:`MEM_AW] == `RAM_PAGE);
  assign port_sel = link.addr[7:0];
  assign kbd_hit = (link.op == OP_IOR) && (port_sel == `PORT_KBD);
  assign ind_hit = (link.op == OP_IOW) && (port_sel == `PORT_IND);
  assign mask_hit = (link.op == OP_IOW) && (port_sel == `PORT_MASK);
  assign tmr_hit = (link.op == OP_IOW) && (port_sel == `PORT_TMR);

  // ----------------------------------------------------------------
  // bus buffers between local and system data bus
  // ----------------------------------------------------------------
  // decode gated with strobe
  assign buf_en = (rd_stb && (rom_hit || ram_hit || kbd_hit))
    || (wr_stb && (ram_hit || ind_hit || mask_hit || tmr_hit));
  assign to_sys = rd_stb;

  always_comb begin
    loc_d = link.data;
    if (buf_en && to_sys) begin
      if (rom_hit) begin
        loc_d = rom_mem[mem_a];
      end else if (ram_hit) begin
        loc_d = ram_mem[mem_a];
      end else begin
        loc_d = kbd_i;
      end
    end
  end

  assign link.dev_oe = (buf_en && to_sys) || inta_stb;
  assign link.dev_d = s_r.rdata;

  // ----------------------------------------------------------------
  // interval timer
  // ----------------------------------------------------------------
  // fractional accumulator: exact mean rate, jitter of one clock
  assign acc_sum = s_r.acc + `ACC_W'(`TMR_INC);
  assign tick = (acc_sum >= `ACC_W'(`TMR_MOD));

  assign carry[0] = tick;
  for (genvar g = 0; g < NSTAGE; g++) begin : g_stage
    assign carry[g+1] = carry[g] && (s_r.cnt[g] == 4'hf);
  end
  assign terminal = carry[NSTAGE];

  // ----------------------------------------------------------------
  // interrupt unit
  // ----------------------------------------------------------------
  // lines 6 and 7 have no mask bit
  assign enable = {2'b11, s_r.mask};
  // low on a line is a request
  assign set_v = (~req_n_i & enable) | {terminal, 7'h00};
  assign clr_v = link.clr_n ? 8'h00 : (8'h01 << s_r.vec);
  assign enc = prio_enc(s_r.status);
  assign vec_now = first_inta ? enc : s_r.vec;
  assign link.intr_n = ~(|s_r.status);
  assign ind_o = s_r.ind;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.op_prev = link.op;
    s_nxt.acc = tick ? `ACC_W'(acc_sum - `ACC_W'(`TMR_MOD)) : acc_sum;
    for (int i = 0; i < NSTAGE; i++) begin
      if (carry[i]) begin
        s_nxt.cnt[i] = s_r.cnt[i] + 4'h1;
      end
    end
    // 256 to 65536 ticks per interval
    if (terminal) begin
      s_nxt.cnt[1:0] = 8'h00;
      s_nxt.cnt[3:2] = s_r.preset;
    end
    // preset upper stages from local bus
    if (tmr_hit) begin
      s_nxt.preset = loc_d;
      s_nxt.cnt[1:0] = 8'h00;
      s_nxt.cnt[3:2] = loc_d;
    end
    if (mask_hit) begin
      s_nxt.mask = loc_d[5:0];
    end
    if (ind_hit) begin
      s_nxt.ind = loc_d;
    end
    // eight independent sticky lines, set beats clear
    s_nxt.status = (s_r.status & ~clr_v) | set_v;
    if (first_inta) begin
      s_nxt.vec = enc;
    end
    if (inta_stb) begin
      s_nxt.rdata = {`VEC_PAD, vec_now};
    end else if (rd_stb) begin
      s_nxt.rdata = loc_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.mask <= `MASK_RST;
      s_r.ind <= `IND_RST;
      s_r.preset <= `PRESET_RST;
      s_r.op_prev <= OP_IDLE;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // program ROM and scratch-pad RAM
  // ----------------------------------------------------------------
  // ROM is filled from the user side before the processor runs
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (rom_wr_i) begin
        rom_mem[rom_addr_i] <= rom_data_i;
      end
      if (wr_stb && ram_hit) begin
        ram_mem[mem_a] <= loc_d;
      end
    end
  end

endmodule : support_dev

// >>> hw/cpu_host.sv
`timescale 1ns/1ns
`include "psit_defs.svh"

module cpu_host #(
  parameter int ACC_CYC = `LINK_ACC_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  cpu_link_if.host link
);
  import psit_pkg::*;

  host_state_t s_r;
  host_state_t s_nxt;
  logic req;
  logic wr;
  logic [1:0] ev;
  logic [31:0] rd_mux;
  logic [2:0] code;

  assign req = wb_cyc_i && wb_stb_i;
  // writes land on the edge that carries ack
  assign wr = req && s_r.ack && wb_we_i;
  assign code = wb_dat_i[2:0];

  always_comb begin
    case (wb_adr_i)
      `REG_ADDR: rd_mux = {16'h0000, s_r.addr};
      `REG_WDATA: rd_mux = {24'h000000, s_r.wdata};
      `REG_CMD: rd_mux = {31'h00000000, s_r.st != H_IDLE};
      `REG_RDATA: rd_mux = {24'h000000, s_r.rdata};
      `REG_ISTAT: rd_mux = {30'h00000000, s_r.istat};
      `REG_IMASK: rd_mux = {30'h00000000, s_r.imask};
      `REG_LINK: rd_mux = {31'h00000000, ~link.intr_n};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    ev = 2'b00;
    s_nxt.ack = req && !s_r.ack;
    s_nxt.intr_prev = link.intr_n;
    if (req && !s_r.ack) begin
      s_nxt.dat = rd_mux;
    end
    // a falling request line is an event
    ev[`EV_INTR] = s_r.intr_prev && !link.intr_n;
    case (s_r.st)
      H_IDLE: begin
        if (wr && wb_adr_i == `REG_CMD && wb_sel_i[0]) begin
          if (code == `CMD_CLR) begin
            s_nxt.clr_n = 1'b0;
            s_nxt.st = H_PULSE;
          end else if (code != 3'h0 && code <= 3'(OP_INTA)) begin
            s_nxt.op = bus_op_t'(code);
            s_nxt.cnt = 8'h00;
            s_nxt.st = H_RUN;
          end
        end
      end
      H_RUN: begin
        s_nxt.cnt = s_r.cnt + 8'h01;
        if (s_r.cnt == 8'(ACC_CYC - 1)) begin
          // read the vector or data at the end
          if (s_r.op == OP_MEMR || s_r.op == OP_IOR
              || s_r.op == OP_INTA) begin
            s_nxt.rdata = link.data;
          end
          s_nxt.op = OP_IDLE;
          s_nxt.st = H_IDLE;
          ev[`EV_DONE] = 1'b1;
        end
      end
      H_PULSE: begin
        s_nxt.clr_n = 1'b1;
        s_nxt.st = H_IDLE;
        ev[`EV_DONE] = 1'b1;
      end
      default: begin
        s_nxt.st = H_IDLE;
      end
    endcase
    if (wr && s_r.st == H_IDLE) begin
      if (wb_adr_i == `REG_ADDR && wb_sel_i[0]) begin
        s_nxt.addr[7:0] = wb_dat_i[7:0];
      end
      if (wb_adr_i == `REG_ADDR && wb_sel_i[1]) begin
        s_nxt.addr[15:8] = wb_dat_i[15:8];
      end
      // mask byte sent on the bus
      // preset byte sent on the bus
      if (wb_adr_i == `REG_WDATA && wb_sel_i[0]) begin
        s_nxt.wdata = wb_dat_i[7:0];
      end
    end
    if (wr && wb_adr_i == `REG_IMASK && wb_sel_i[0]) begin
      s_nxt.imask = wb_dat_i[1:0];
    end
    // set wins over a write-one clear
    if (wr && wb_adr_i == `REG_ISTAT && wb_sel_i[0]) begin
      s_nxt.istat = (s_r.istat & ~wb_dat_i[1:0]) | ev;
    end else begin
      s_nxt.istat = s_r.istat | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.st <= H_IDLE;
      s_r.op <= OP_IDLE;
      s_r.clr_n <= 1'b1;
      s_r.intr_prev <= 1'b1;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;
  assign irq_o = |(s_r.istat & s_r.imask);
  assign link.op = s_r.op;
  assign link.addr = s_r.addr;
  assign link.host_d = s_r.wdata;
  assign link.host_oe = (s_r.op == OP_MEMW) || (s_r.op == OP_IOW);
  assign link.clr_n = s_r.clr_n;

endmodule : cpu_host

// >>> sim/link_props.sv
`timescale 1ns/1ns
// --------
// link checks
// --------
module link_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input psit_pkg::bus_op_t op,
  input wire logic [15:0] addr,
  input psit_pkg::byte_t host_d,
  input wire logic host_oe,
  input psit_pkg::byte_t dev_d,
  input wire logic dev_oe,
  input wire logic intr_n,
  input wire logic clr_n,
  input psit_pkg::byte_t data
);
  import psit_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // far side decodes every cycle, so the request must not wander
  op_hold_a: assert property (
    (op != OP_IDLE && $past(op) == OP_IDLE) |=>
    ($stable(op) && $stable(addr) && $stable(host_d)) [*2] ##1 op == OP_IDLE)
    else $error("link request not held");
  clr_pulse_a: assert property (
    $fell(clr_n) |=> clr_n) else $error("clear pulse too long");
  host_drive_a: assert property (
    host_oe == (op == OP_MEMW || op == OP_IOW))
    else $error("host drive enable wrong");
  dev_drive_a: assert property (
    dev_oe |-> (op == OP_MEMR || op == OP_IOR || op == OP_INTA))
    else $error("device drives outside a read");
  mem_map_a: assert property (
    op == OP_MEMR |-> dev_oe == (addr[15:11] == 5'h00))
    else $error("memory decode wrong");
  vec_pad_a: assert property (
    (op == OP_INTA && $past(op) == OP_INTA) |-> dev_oe && dev_d[7:3] == 5'h00)
    else $error("vector read not padded");
  vec_hold_a: assert property (
    (op == OP_INTA && $past(op) == OP_INTA && $past(op, 2) == OP_INTA)
    |-> $stable(dev_d)) else $error("vector moved during read");
  intr_idle_a: assert property (
    $fell(rst_i) |-> intr_n) else $error("request pending after reset");
endmodule : link_props

// >>> sim/tb_top.sv
`timescale 1ns/1ns
`include "psit_defs.svh"
module tb_top;
  import psit_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, rom_wr, intr_q;
  logic [7:0] adr, req_n;
  logic [3:0] sel;
  logic [31:0] dw, dr;
  logic [9:0] rom_a;
  byte_t kbd, ind, rom_d;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc_n = 0;
  int t_fall[$];
  byte_t mem_m[int];
  cpu_link_if link();

  cpu_host #(.ACC_CYC(3)) i_cpu_host (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .irq_o(irq), .link(link));
  support_dev i_support_dev (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .link(link), .req_n_i(req_n), .kbd_i(kbd), .ind_o(ind),
    .rom_wr_i(rom_wr), .rom_addr_i(rom_a), .rom_data_i(rom_d));
  link_props i_link_props (.clk_i(clk_i), .rst_i(rst_i), .op(link.op),
    .addr(link.addr), .host_d(link.host_d), .host_oe(link.host_oe),
    .dev_d(link.dev_d), .dev_oe(link.dev_oe), .intr_n(link.intr_n),
    .clr_n(link.clr_n), .data(link.data));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // --------
  // checks and bus tasks
  // --------
  task automatic err(input string m);
    $display("[ERR] t=%0t %s", $time, m);
    n_mismatch++;
  endtask : err
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e,
                         input string m);
    n_compared++;
    if (g !== e) err($sformatf("%s got %h exp %h", m, g, e));
  endtask : chk_val
  task automatic chk_flag(input logic g, input logic e, input string m);
    n_compared++;
    if (g !== e) err($sformatf("%s got %b exp %b", m, g, e));
  endtask : chk_flag
  task automatic chk_gap(input int g, input int e, input string m);
    n_compared++;
    if (g < e - 1 || g > e + 1) err($sformatf("%s %0d vs %0d", m, g, e));
  endtask : chk_gap
  task end_sim;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim

  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    intr_q <= link.intr_n;
    if (!rst_i && intr_q === 1'b1 && link.intr_n === 1'b0)
      t_fall.push_back(cyc_n);
    if (cyc_n == 90000) begin
      err("run timeout");
      end_sim();
    end
  end

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 40);
    if (n >= 40) err("bus answer missing");
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask : rd
  // one device access through the host's command registers
  task automatic lop(input logic [2:0] c, input logic [15:0] a,
                     input byte_t d, output byte_t q);
    logic [31:0] r;
    int n;
    wr(`REG_ADDR, {16'h0, a});
    wr(`REG_WDATA, {24'h0, d});
    wr(`REG_CMD, {29'h0, c});
    n = 0;
    do begin
      rd(`REG_CMD, r);
      n++;
    end while (r[0] !== 1'b0 && n < 20);
    if (n >= 20) err("link access hung");
    rd(`REG_RDATA, r);
    q = r[7:0];
  endtask : lop

  // --------
  // main sequence
  // --------
  initial begin
    byte_t q, v;
    logic [31:0] r;
    logic [5:0] m;
    int a, b, n;
    logic en;
    rst_i = 1'b1;
    {cyc, stb, we, rom_wr} = 4'h0;
    sel = 4'hf;
    adr = 8'h00;
    dw = 32'h0;
    req_n = 8'hff;
    kbd = 8'h00;
    rom_a = 10'h000;
    rom_d = 8'h00;
    void'($urandom(32'haa40));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      v = $urandom;
      rom_wr <= 1'b1;
      rom_a <= i ? 10'h3ff : 10'h000;
      rom_d <= v;
      mem_m[i ? 1023 : 0] = v;
    end
    @(posedge clk_i);
    rom_wr <= 1'b0;
    rd(`REG_LINK, r);
    chk_flag(r[0], 1'b0, "pending at reset");
    chk_val(ind, `IND_RST, "indicator reset");
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      a = 16'h0400 + ($urandom & 16'h03ff);
      v = $urandom;
      lop(OP_MEMW, a[15:0], v, q);
      mem_m[a] = v;
    end
    foreach (mem_m[i]) begin
      lop(OP_MEMR, i[15:0], 8'h00, q);
      chk_val(q, mem_m[i], "memory read");
    end
    lop(OP_MEMR, 16'h0800, 8'h00, q);
    chk_val(q, `BUS_FLOAT, "unmapped read");
    $display("test memory done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      kbd <= 8'($urandom);
      lop(OP_IOR, {8'h0, `PORT_KBD}, 8'h00, q);
      chk_val(q, kbd, "keyboard read");
      v = $urandom;
      lop(OP_IOW, {8'h0, `PORT_IND}, v, q);
      chk_val(ind, v, "indicator port");
    end
    $display("test ports done");
    wr(`REG_IMASK, 32'h2);
    for (int ln = 0; ln < 8; ln++) begin
      m = $urandom;
      en = (ln > 5) || m[ln];
      lop(OP_IOW, {8'h0, `PORT_MASK}, {2'b00, m}, q);
      wr(`REG_ISTAT, 32'h3);
      @(posedge clk_i);
      req_n <= ~(8'h01 << ln);
      repeat (2) @(posedge clk_i);
      req_n <= 8'hff;
      rd(`REG_LINK, r);
      chk_flag(r[0], en, "masked request");
      chk_flag(irq, en, "host interrupt");
      if (en) begin
        lop(OP_INTA, 16'h0, 8'h00, q);
        chk_val(q, ln, "vector");
        lop(`CMD_CLR, 16'h0, 8'h00, q);
        rd(`REG_LINK, r);
        chk_flag(r[0], 1'b0, "cleared");
      end
    end
    wr(`REG_IMASK, 32'h0);
    @(negedge clk_i);
    chk_flag(irq, 1'b0, "masked irq");
    wr(`REG_IMASK, 32'h2);
    @(negedge clk_i);
    chk_flag(irq, 1'b1, "unmasked irq");
    wr(`REG_ISTAT, 32'h3);
    @(negedge clk_i);
    chk_flag(irq, 1'b0, "irq cleared");
    a = $urandom_range(5, 0);
    b = $urandom_range(7, a + 1);
    lop(OP_IOW, {8'h0, `PORT_MASK}, 8'h3f, q);
    @(posedge clk_i);
    req_n <= ~((8'h01 << a) | (8'h01 << b));
    repeat (2) @(posedge clk_i);
    req_n <= 8'hff;
    lop(OP_INTA, 16'h0, 8'h00, q);
    chk_val(q, b, "highest first");
    lop(`CMD_CLR, 16'h0, 8'h00, q);
    rd(`REG_LINK, r);
    chk_flag(r[0], 1'b1, "lower still pending");
    lop(OP_INTA, 16'h0, 8'h00, q);
    chk_val(q, a, "lower next");
    lop(`CMD_CLR, 16'h0, 8'h00, q);
    $display("test interrupts done");
    t_fall.delete();
    lop(OP_IOW, {8'h0, `PORT_TMR}, 8'hff, q);
    n = 0;
    while (t_fall.size() < 1 && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    lop(OP_INTA, 16'h0, 8'h00, q);
    chk_val(q, 7, "timer vector");
    lop(`CMD_CLR, 16'h0, 8'h00, q);
    n = 0;
    while (t_fall.size() < 2 && n < 40000) begin
      @(posedge clk_i);
      n++;
    end
    if (t_fall.size() < 2) err("timer did not repeat");
    else chk_gap(t_fall[1] - t_fall[0],
      ((65536 - 256 * 255) * `TMR_MOD) / `TMR_INC, "timer interval");
    $display("test timer done");
    end_sim();
  end
endmodule : tb_top
